// File: shared/mipc_pkg.sv
// Purpose: Shared constants and types for the mic input path control bank
// Assumes: Classic Wishbone slave, 32-bit data, 9-bit registers in low bits
// Notes:   Printed offsets are not all multiples of four, so byte address = 4 * index
`default_nettype none
package mipc_pkg;
	// Register indices as printed
	localparam logic [7:0] IDX_POWER_ONE   = 8'h01;
	localparam logic [7:0] IDX_POWER_TWO   = 8'h02;
	localparam logic [7:0] IDX_LEVEL_ONE   = 8'h20;
	localparam logic [7:0] IDX_ROUTING     = 8'h2C;
	localparam logic [7:0] IDX_AMP_GAIN    = 8'h2D;
	localparam logic [7:0] IDX_BOOST_GAIN  = 8'h2F;
	// Extra status register, holds the gain actually in force
	localparam logic [7:0] IDX_GAIN_STATUS = 8'h30;
	localparam int         REG_W           = 9;

	// Field positions
	localparam int BIT_AUX_EN        = 6;
	localparam int BIT_BIAS_EN       = 4;
	localparam int BIT_BOOST_EN      = 4;
	localparam int BIT_AUTO_SEL      = 8;
	localparam int BIT_POS_ROUTE     = 0;
	localparam int BIT_NEG_ROUTE     = 1;
	localparam int BIT_AUX_ROUTE     = 2;
	localparam int BIT_AUX_MODE      = 3;
	localparam int BIT_BIAS_LEVEL    = 8;
	localparam int GAIN_LSB          = 0;
	localparam int GAIN_W            = 6;
	localparam int BIT_MUTE          = 6;
	localparam int BIT_ZC_EN         = 7;
	localparam int AUX_BOOST_LSB     = 0;
	localparam int POS_BOOST_LSB     = 4;
	localparam int BOOST_CODE_W      = 3;
	localparam int BIT_AMP_BOOST     = 8;
	localparam int BIT_PENDING       = 8;

	// Reset values
	localparam logic [8:0] RST_POWER_ONE  = 9'h000;
	localparam logic [8:0] RST_POWER_TWO  = 9'h000;
	localparam logic [8:0] RST_LEVEL_ONE  = 9'h000;
	localparam logic [8:0] RST_ROUTING    = 9'h003;
	localparam logic [8:0] RST_AMP_GAIN   = 9'h010;
	localparam logic [8:0] RST_BOOST_GAIN = 9'h100;

	// Gain code meanings
	localparam logic [5:0] GAIN_CODE_0DB  = 6'h10;
	localparam logic [2:0] BOOST_OFF_CODE = 3'h0;

	// Analogue control bundle driven to the front end
	typedef struct packed {
		logic       aux_amp_enable;
		logic       aux_bypass_switch;
		logic       amp_power;
		logic [5:0] amp_gain_code;
		logic       gain_from_auto;
		logic       amp_mute;
		logic       amp_to_boost_connect;
		logic       amp_to_boost_gain;
		logic [2:0] aux_to_boost_gain;
		logic [2:0] pos_mic_to_boost_gain;
		logic       boost_stage_enable;
		logic       pos_mic_route;
		logic       neg_mic_route;
		logic       aux_route;
		logic       mic_bias_enable;
		logic       mic_bias_level_select;
	} mipc_analog_s;
endpackage : mipc_pkg
`default_nettype wire

// File: hdl/mipc_top.sv
// Purpose: Register bank steering the analogue record front end
// Assumes: Classic Wishbone slave; zero crossing flagged by the analogue side
// Notes:   Gain changes deferred by zero-cross are held until the crossing
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Six-bit gain code, 0.75dB linear steps
// - One gain code drives all amp inputs
// - Auto select bit picks automatic gain source
// - Mute silences amp, cuts boost link
// - Zero-cross bit defers gain to crossing
// - Aux amp powered only when enabled
// - Aux mode closes bypass switch when set
// - Amp-to-boost bit selects +20dB, resets one
// - Aux-to-boost code zero disconnects path
// - Pos mic-to-boost code zero disconnects pin
// - Boost stage powered only when enabled
// - Bias enabled drives output, else floats
// - Bias level select picks supply fraction
// - Routing bit ties amp plus to pin
module mipc_top (
	// Clock and reset
	input  wire logic                   REF_CLK,
	input  wire logic                   RST_B,
	// Wishbone slave
	input  wire logic                   CYC_I,
	input  wire logic                   STB_I,
	input  wire logic                   WE_I,
	input  wire logic [9:0]             ADR_I,
	input  wire logic [3:0]             SEL_I,
	input  wire logic [31:0]            DAT_I,
	output logic      [31:0]            DAT_O,
	output logic                        ACK_O,
	output logic                        ERR_O,
	// Analogue side events
	input  wire logic                   ZERO_CROSS,
	// Analogue controls
	output var mipc_pkg::mipc_analog_s  ANALOG_CTRL,
	// Bias pin as output plus enable
	output logic                        MIC_BIAS_OUTPUT_OE
);
	import mipc_pkg::*;

	// Software visible registers
	logic [REG_W-1:0] power_control_one, next_power_control_one;
	logic [REG_W-1:0] power_control_two, next_power_control_two;
	logic [REG_W-1:0] level_control_one, next_level_control_one;
	logic [REG_W-1:0] input_routing,     next_input_routing;
	logic [REG_W-1:0] input_amp_gain,    next_input_amp_gain;
	logic [REG_W-1:0] boost_stage_gain,  next_boost_stage_gain;
	// Gain actually applied, and a deferred-change marker
	logic [GAIN_W-1:0] active_gain,      next_active_gain;
	logic              gain_pending,     next_gain_pending;
	// Bus answer state
	logic              ack,              next_ack;
	logic              err,              next_err;
	logic [31:0]       rdata,            next_rdata;
	// Bus decode helpers
	logic        req;
	logic        word_ok;
	logic [7:0]  idx;
	logic        hit;
	logic        wr_lo;
	logic        wr_hi;
	logic        gain_write;
	logic [8:0]  wdata;

	// Only a fresh request is taken; ack drops the cycle after
	assign req   = CYC_I && STB_I && !ack && !err;
	assign idx   = ADR_I[9:2];
	// Byte offset must be zero for a word register
	assign word_ok = (ADR_I[1:0] == 2'h0);
	assign wr_lo = req && WE_I && SEL_I[0];
	assign wr_hi = req && WE_I && SEL_I[1];

	// Address decode
	always_comb begin
		if (!word_ok) begin
			hit = 1'b0;
		end else if (idx == IDX_POWER_ONE || idx == IDX_POWER_TWO || idx == IDX_LEVEL_ONE) begin
			hit = 1'b1;
		end else if (idx == IDX_ROUTING || idx == IDX_AMP_GAIN || idx == IDX_BOOST_GAIN) begin
			hit = 1'b1;
		end else if (idx == IDX_GAIN_STATUS) begin
			hit = 1'b1;
		end else begin
			hit = 1'b0;
		end
	end

	// Merge write data by byte lanes; bit 8 lives in lane one
	function automatic logic [8:0] merge(input logic [8:0] old);
		logic [8:0] m;
		m = old;
		if (wr_lo) begin
			m[7:0] = DAT_I[7:0];
		end
		if (wr_hi) begin
			m[8] = DAT_I[8];
		end
		return m;
	endfunction : merge

	assign wdata      = merge(input_amp_gain);
	// A gain write counts only when the code byte lane is written
	assign gain_write = hit && wr_lo && idx == IDX_AMP_GAIN;

	// Register write next values
	always_comb begin
		next_power_control_one = power_control_one;
		next_power_control_two = power_control_two;
		next_level_control_one = level_control_one;
		next_input_routing     = input_routing;
		next_input_amp_gain    = input_amp_gain;
		next_boost_stage_gain  = boost_stage_gain;
		if (hit && WE_I && req) begin
			if (idx == IDX_POWER_ONE) begin
				next_power_control_one = merge(power_control_one);
			end else if (idx == IDX_POWER_TWO) begin
				next_power_control_two = merge(power_control_two);
			end else if (idx == IDX_LEVEL_ONE) begin
				next_level_control_one = merge(level_control_one);
			end else if (idx == IDX_ROUTING) begin
				next_input_routing = merge(input_routing);
			end else if (idx == IDX_AMP_GAIN) begin
				next_input_amp_gain = wdata;
			end else if (idx == IDX_BOOST_GAIN) begin
				next_boost_stage_gain = merge(boost_stage_gain);
			end
		end
	end

	// Applied gain: immediate or held for the zero crossing
	always_comb begin
		next_active_gain  = active_gain;
		next_gain_pending = gain_pending;
		if (gain_write && !wdata[BIT_ZC_EN]) begin
			// Immediate update, drops any older pending change
			next_active_gain  = wdata[GAIN_LSB +: GAIN_W];
			next_gain_pending = 1'b0;
		end else if (gain_write) begin
			// Newest code waits; old gain stays applied
			next_gain_pending = 1'b1;
			// A crossing in the same cycle is ignored; the newest code waits for a later crossing
		end else if (gain_pending && ZERO_CROSS) begin
			// First crossing after the write applies the latest held code
			next_active_gain  = input_amp_gain[GAIN_LSB +: GAIN_W];
			next_gain_pending = 1'b0;
		end
	end

	// Bus answer: one-cycle ack for mapped words, err otherwise
	always_comb begin
		next_ack   = req && hit;
		next_err   = req && !hit;
		next_rdata = 32'h0000_0000;
		if (req && hit && !WE_I) begin
			if (idx == IDX_POWER_ONE) begin
				next_rdata[8:0] = power_control_one;
			end else if (idx == IDX_POWER_TWO) begin
				next_rdata[8:0] = power_control_two;
			end else if (idx == IDX_LEVEL_ONE) begin
				next_rdata[8:0] = level_control_one;
			end else if (idx == IDX_ROUTING) begin
				next_rdata[8:0] = input_routing;
			end else if (idx == IDX_AMP_GAIN) begin
				next_rdata[8:0] = input_amp_gain;
			end else if (idx == IDX_BOOST_GAIN) begin
				next_rdata[8:0] = boost_stage_gain;
			end else begin
				// Status: applied gain plus pending flag
				next_rdata[GAIN_LSB +: GAIN_W] = active_gain;
				next_rdata[BIT_PENDING]        = gain_pending;
			end
		end
	end

	// State registers
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			power_control_one <= RST_POWER_ONE;
			power_control_two <= RST_POWER_TWO;
			level_control_one <= RST_LEVEL_ONE;
			input_routing     <= RST_ROUTING;
			input_amp_gain    <= RST_AMP_GAIN;
			boost_stage_gain  <= RST_BOOST_GAIN;
			active_gain       <= GAIN_CODE_0DB;
			gain_pending      <= 1'b0;
			ack               <= 1'b0;
			err               <= 1'b0;
			rdata             <= 32'h0000_0000;
		end else begin
			power_control_one <= next_power_control_one;
			power_control_two <= next_power_control_two;
			level_control_one <= next_level_control_one;
			input_routing     <= next_input_routing;
			input_amp_gain    <= next_input_amp_gain;
			boost_stage_gain  <= next_boost_stage_gain;
			active_gain       <= next_active_gain;
			gain_pending      <= next_gain_pending;
			ack               <= next_ack;
			err               <= next_err;
			rdata             <= next_rdata;
		end
	end

	assign ACK_O = ack;
	assign ERR_O = err;
	assign DAT_O = rdata;

	// Analogue control decode, straight from flops
	always_comb begin
		ANALOG_CTRL.aux_amp_enable        = power_control_one[BIT_AUX_EN];
		// Bypass only meaningful in mixer mode
		ANALOG_CTRL.aux_bypass_switch     = input_routing[BIT_AUX_MODE];
		// Amp stays powered; mute isolates it instead
		ANALOG_CTRL.amp_power             = 1'b1;
		// One code, linear 0.75dB per step, shared by every amp input
		ANALOG_CTRL.amp_gain_code         = active_gain;
		// Auto level control overrides the manual code
		ANALOG_CTRL.gain_from_auto        = level_control_one[BIT_AUTO_SEL];
		ANALOG_CTRL.amp_mute              = input_amp_gain[BIT_MUTE];
		ANALOG_CTRL.amp_to_boost_connect  = !input_amp_gain[BIT_MUTE];
		ANALOG_CTRL.amp_to_boost_gain     = boost_stage_gain[BIT_AMP_BOOST];
		// Code zero means disconnected; the front end decodes steps of 3dB
		ANALOG_CTRL.aux_to_boost_gain     = boost_stage_gain[AUX_BOOST_LSB +: BOOST_CODE_W];
		ANALOG_CTRL.pos_mic_to_boost_gain = boost_stage_gain[POS_BOOST_LSB +: BOOST_CODE_W];
		ANALOG_CTRL.boost_stage_enable    = power_control_two[BIT_BOOST_EN];
		// Pos pin also takes the shared gain when routed
		ANALOG_CTRL.pos_mic_route         = input_routing[BIT_POS_ROUTE];
		ANALOG_CTRL.neg_mic_route         = input_routing[BIT_NEG_ROUTE];
		ANALOG_CTRL.aux_route             = input_routing[BIT_AUX_ROUTE];
		ANALOG_CTRL.mic_bias_enable       = power_control_one[BIT_BIAS_EN];
		ANALOG_CTRL.mic_bias_level_select = input_routing[BIT_BIAS_LEVEL];
	end

	// Bias pad floats when disabled
	assign MIC_BIAS_OUTPUT_OE = power_control_one[BIT_BIAS_EN];

	// Unused bus bits are intentionally ignored
	logic unused_ok;
	assign unused_ok = ^{DAT_I[31:9], SEL_I[3:2]};

endmodule : mipc_top
`default_nettype wire

// File: tb/mipc_assertions.sv
// Purpose: Port checks for the mic input path bank
// Assumes: One clock, async active-low reset
// Notes:   Bound onto mipc_top
`timescale 1ns/1ps
`default_nettype none
module mipc_checker (
	// Clock, reset, bus
	input wire logic                   REF_CLK,
	input wire logic                   RST_B,
	input wire logic                   CYC_I,
	input wire logic                   STB_I,
	input wire logic                   WE_I,
	input wire logic [9:0]             ADR_I,
	input wire logic [3:0]             SEL_I,
	input wire logic [31:0]            DAT_I,
	input wire logic [31:0]            DAT_O,
	input wire logic                   ACK_O,
	input wire logic                   ERR_O,
	// Analogue side
	input wire logic                   ZERO_CROSS,
	input wire mipc_pkg::mipc_analog_s ANALOG_CTRL,
	input wire logic                   MIC_BIAS_OUTPUT_OE
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);
	// Request taken this edge
	sequence s_take;
		CYC_I && STB_I && !ACK_O && !ERR_O;
	endsequence
	// Full write to the boost register
	sequence s_boost_wr;
		s_take ##0 (WE_I && ADR_I == 10'h0BC && SEL_I[1:0] == 2'h3);
	endsequence
	// Immediate gain write, zero-cross off
	sequence s_gain_now;
		s_take ##0 (WE_I && ADR_I == 10'h0B4 && SEL_I[0] && !DAT_I[7]);
	endsequence
	chk_ack_answer: assert property (s_take |=> ACK_O || ERR_O) else $error("no answer");
	chk_ack_pulse: assert property (ACK_O || ERR_O |=> !ACK_O && !ERR_O) else $error("long answer");
	chk_dat_idle: assert property (!ACK_O |-> DAT_O == 32'h0) else $error("read data not idle");
	chk_mute_link: assert property (ANALOG_CTRL.amp_to_boost_connect != ANALOG_CTRL.amp_mute) else $error("mute link");
	chk_bias_float: assert property (MIC_BIAS_OUTPUT_OE == ANALOG_CTRL.mic_bias_enable) else $error("bias drive");
	chk_gain_now: assert property (s_gain_now |=> ANALOG_CTRL.amp_gain_code == $past(DAT_I[5:0]))
		else $error("gain not applied");
	chk_gain_hold: assert property ($changed(ANALOG_CTRL.amp_gain_code) |-> ACK_O || $past(ZERO_CROSS))
		else $error("gain moved alone");
	chk_boost_codes: assert property (s_boost_wr |=> ANALOG_CTRL.amp_to_boost_gain == $past(DAT_I[8])
		&& ANALOG_CTRL.aux_to_boost_gain == $past(DAT_I[2:0])) else $error("boost codes");
endmodule : mipc_checker
bind mipc_top mipc_checker chk_i (.REF_CLK(REF_CLK), .RST_B(RST_B), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
	.ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .ERR_O(ERR_O),
	.ZERO_CROSS(ZERO_CROSS), .ANALOG_CTRL(ANALOG_CTRL), .MIC_BIAS_OUTPUT_OE(MIC_BIAS_OUTPUT_OE));
`default_nettype wire

// File: tb/mipc_top_test.sv
// Purpose: Self-checking bench for the mic input path bank
// Assumes: Wishbone master tasks, model of registers and applied gain
// Notes:   Random writes land on mapped registers only
`timescale 1ns/1ps
`default_nettype none
module mipc_top_test;
	import mipc_pkg::*;
	logic               REF_CLK = 0, RST_B = 0, CYC_I = 0, STB_I = 0, WE_I = 0, ZERO_CROSS = 0;
	logic [9:0]         ADR_I = 10'h0;
	logic [3:0]         SEL_I = 4'h0;
	logic [31:0]        DAT_I = 32'h0, DAT_O, q;
	logic               ACK_O, ERR_O, MIC_BIAS_OUTPUT_OE, e;
	mipc_analog_s       ANALOG_CTRL;
	int                 errors = 0, n_checks = 0, cyc = 0, i, k;
	logic [8:0]         d;
	// Model: registers, applied gain, pending flag
	logic [8:0]         m [6] = '{9'h000, 9'h000, 9'h000, 9'h003, 9'h010, 9'h100};
	logic [9:0]         adr [6] = '{10'h004, 10'h008, 10'h080, 10'h0B0, 10'h0B4, 10'h0BC};
	logic [5:0]         ag = 6'h10;
	logic               pend = 0;
	mipc_top dut (.REF_CLK(REF_CLK), .RST_B(RST_B), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
		.SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .ERR_O(ERR_O), .ZERO_CROSS(ZERO_CROSS),
		.ANALOG_CTRL(ANALOG_CTRL), .MIC_BIAS_OUTPUT_OE(MIC_BIAS_OUTPUT_OE));
	always #5 REF_CLK = ~REF_CLK;
	// Hang guard
	always @(posedge REF_CLK) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			print_verdict();
		end
	end
	task cmp(input logic [31:0] g, input logic [31:0] x);
		n_checks++;
		if (g !== x) begin
			errors++;
			$display("wrong value t=%0t got %h exp %h", $time, g, x);
		end
	endtask : cmp
	// One classic cycle, held until answered
	task wb(input logic w, input logic [9:0] a, input logic [31:0] d);
		@(posedge REF_CLK);
		{CYC_I, STB_I, WE_I, ADR_I, DAT_I, SEL_I} <= {2'h3, w, a, d, 4'hF};
		do @(posedge REF_CLK); while (!(ACK_O | ERR_O));
		q = DAT_O;
		e = ERR_O;
		{CYC_I, STB_I} <= 2'h0;
	endtask : wb
	// Write one register, update the model
	task wr(input int k, input logic [8:0] d);
		wb(1'b1, adr[k], {23'h0, d});
		m[k] = d;
		if (k == 4 && !d[7]) {ag, pend} = {d[5:0], 1'b0};
		if (k == 4 && d[7]) pend = 1'b1;
	endtask : wr
	// Crossing pulse in a later cycle
	task zc();
		@(posedge REF_CLK) ZERO_CROSS <= 1'b1;
		@(posedge REF_CLK) ZERO_CROSS <= 1'b0;
		if (pend) {ag, pend} = {m[4][5:0], 1'b0};
	endtask : zc
	// Analogue bundle and status against the model
	task chk_ctrl();
		@(posedge REF_CLK);
		cmp(ANALOG_CTRL, {m[0][6], m[3][3], 1'b1, ag, m[2][8], m[4][6], !m[4][6], m[5][8], m[5][2:0], m[5][6:4],
			m[1][4], m[3][0], m[3][1], m[3][2], m[0][4], m[3][8]});
		cmp(MIC_BIAS_OUTPUT_OE, m[0][4]);
		wb(1'b0, 10'h0C0, 32'h0);
		cmp(q, {23'h0, pend, 2'h0, ag});
	endtask : chk_ctrl
	task rd_all();
		for (i = 0; i < 6; i++) begin
			wb(1'b0, adr[i], 32'h0);
			cmp(q, {23'h0, m[i]});
		end
	endtask : rd_all
	task print_verdict();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	initial begin
		void'($urandom(22433));
		repeat (4) @(posedge REF_CLK);
		RST_B <= 1'b1;
		rd_all();
		chk_ctrl();
		$display("test reset done");
		// Random writes, crossings now and then
		repeat (60) begin
			k = $urandom % 6;
			d = $urandom;
			// Random level writes keep the auto select bit clear, so manual gain control stays
			if (k == 2) d[8] = 1'b0;
			wr(k, d);
			if ($urandom % 3 == 0) zc();
			chk_ctrl();
		end
		rd_all();
		$display("test random done");
		// Two deferred writes, newest wins at crossing
		wr(4, 9'h0BF);
		wr(4, 9'h0A5);
		chk_ctrl();
		zc();
		chk_ctrl();
		$display("test zero cross done");
		// Direct pos mic boost path with the pin taken off the amp
		wr(3, 9'h002);
		wr(5, 9'h170);
		chk_ctrl();
		// Auto level on: code left alone, select bit seen at the front end
		wr(2, 9'h100);
		chk_ctrl();
		wr(2, 9'h000);
		chk_ctrl();
		$display("test routing done");
		// Unmapped and misaligned both refused
		wb(1'b1, 10'h3FC, 32'h1FF);
		cmp(e, 1'b1);
		wb(1'b0, 10'h0B5, 32'h0);
		cmp(e, 1'b1);
		rd_all();
		$display("test refuse done");
		print_verdict();
	end
endmodule : mipc_top_test
`default_nettype wire
